// ===== tb/host_model.sv
// Host controller model: absolute-data request and serial frame receiver
`timescale 1ns/10ps
`default_nettype none
module host_model (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ask,
   input wire logic line,
   input wire logic quad_a,
   output logic abs_req,
   output logic [15:0] word,
   output logic [7:0] frames,
   output logic a_bad
);
   import servo_status_pkg::*;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) abs_req <= 1'b0;
      else abs_req <= ask;
   end
   // Mid-bit sampling keeps clear of the one-cycle output lag
   initial begin
      frames = 8'h00;
      a_bad = 1'b0;
      forever begin
         do @(posedge pclk); while (!(presetn === 1'b1 && line === 1'b0));
         repeat (SER_HALF_CYC) @(posedge pclk);
         for (int i = 0; i < 16; i++) begin
            repeat (SER_BIT_CYC) @(posedge pclk);
            word[i] = line;
            if (abs_req === 1'b1 && quad_a !== line) a_bad = 1'b1;
         end
         repeat (SER_BIT_CYC) @(posedge pclk);
         if (line !== 1'b1) a_bad = 1'b1;
         frames = frames + 8'h01;
      end
   end
endmodule : host_model
`default_nettype wire

// ===== tb/servo_status_out_tb.sv
// Testbench for the servo status output block
`timescale 1ns/10ps
`default_nettype none
module servo_status_out_tb;
   import servo_status_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, e, warning_in = 1'b0, alarm_in = 1'b0, ask = 1'b0, abs_req;
   logic [23:0] pos_err = 24'h0;
   logic [15:0] speed_cmd = 16'h0, speed_meas = 16'h0, torque_out = 16'h0;
   logic [15:0] rev_count = 16'h0, word;
   logic [2:0] alarm_code_in = 3'h0;
   wire [2:0] al;
   logic ce = 1'b1;
   enc_in_t enc = 3'h0;
   wire [6:0] flg;
   logic brk, flt, qa, qb, qc, ser, mark, irq, a_bad;
   logic [7:0] frames;
   int fails = 0, cmp_count = 0;
   always #12.5 pclk = ~pclk;
   servo_status_out dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .pos_err(pos_err), .speed_cmd(speed_cmd),
      .speed_meas(speed_meas), .torque_out(torque_out), .warning_in(warning_in),
      .alarm_in(alarm_in), .alarm_code_in(alarm_code_in), .enc(enc), .rev_count(rev_count),
      .abs_req(abs_req), .positioning_done_flag(flg[6]), .approach_flag(flg[5]),
      .speed_match_flag(flg[4]), .rotation_detect_flag(flg[3]), .torque_limit_flag(flg[2]),
      .speed_limit_flag(flg[1]), .warning_flag(flg[0]), .brake_control_out(brk),
      .alarm_code_bit0(al[0]), .alarm_code_bit1(al[1]), .alarm_code_bit2(al[2]),
      .fault_output(flt), .quad_out_a(qa), .quad_out_b(qb), .index_out_c(qc),
      .revolution_serial_out(ser), .index_mark_out(mark), .irq(irq));
   host_model host_u (.pclk(pclk), .presetn(presetn), .ask(ask), .line(ser), .quad_a(qa),
      .abs_req(abs_req), .word(word), .frames(frames), .a_bad(a_bad));
   task automatic stop_test;
      if (fails == 0 && cmp_count > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         $display("CHECK FAILED %0t %s", $time, msg);
         fails++;
      end
   endtask : chk
   task automatic ticks(input int n);
      repeat (n) @(posedge pclk);
   endtask : ticks
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 50);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (pready !== 1'b1) begin
         fails++;
         stop_test();
      end
   endtask : apb
   task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic er, input string m);
      apb(1'b0, a, 32'h0);
      chk(r, x, m);
      chk({31'h0, e}, {31'h0, er}, m);
   endtask : rd
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task automatic flags(input logic [23:0] p, input logic [15:0] c, input logic [15:0] m,
         input logic [15:0] t, input logic w, input logic [6:0] x);
      @(posedge pclk);
      pos_err <= p;
      speed_cmd <= c;
      speed_meas <= m;
      torque_out <= t;
      warning_in <= w;
      // Two control ticks so a tick after the change is certain
      ticks(2 * CTRL_CYC + 3);
      chk({25'h0, flg}, {25'h0, x}, "status flags");
   endtask : flags
   initial begin
      ticks(20);
      presetn <= 1'b1;
      ticks(2);
      rd(CTRL_OFS, 32'h0, 1'b0, "ctrl reset");
      rd(COMPL_W_OFS, 32'ha, 1'b0, "completion width reset");
      rd(APPR_W_OFS, 32'h64, 1'b0, "approach width reset");
      rd(COINC_W_OFS, 32'ha, 1'b0, "coincidence width reset");
      rd(ROT_LVL_OFS, 32'h14, 1'b0, "rotation level reset");
      rd(TRQ_LIM_OFS, 32'h7fff, 1'b0, "torque limit reset");
      rd(SPD_LIM_OFS, 32'h7fff, 1'b0, "speed limit reset");
      rd(INT_MASK_OFS, 32'h0, 1'b0, "mask reset");
      rd(8'h2c, 32'h0, 1'b1, "unmapped address");
      flags(24'hfffff6, 16'h0064, 16'h005a, 16'h0, 1'b0, 7'h78);
      flags(24'h00000b, 16'h0064, 16'h0059, 16'h0, 1'b0, 7'h28);
      flags(24'hffff9b, 16'h0000, 16'h0014, 16'h0, 1'b0, 7'h00);
      wr(TRQ_LIM_OFS, 32'h32);
      wr(SPD_LIM_OFS, 32'h5a);
      flags(24'h000064, 16'h005a, 16'hffa6, 16'hffce, 1'b1, 7'h2f);
      wr(CTRL_OFS, 32'h1);
      flags(24'h000000, 16'h0005, 16'h0005, 16'h0031, 1'b0, 7'h10);
      rd(STATUS_OFS, 32'h4, 1'b0, "status register");
      wr(CTRL_OFS, 32'h10);
      wr(INT_MASK_OFS, 32'h4);
      ticks(3);
      chk({30'h0, brk, irq}, 32'h2, "brake released, irq idle");
      @(posedge pclk);
      alarm_in <= 1'b1;
      alarm_code_in <= 3'h5;
      ticks(4);
      chk({26'h0, al, flt, brk, irq}, 32'h2d, "alarm outputs");
      rd(ALARM_OFS, 32'hd, 1'b0, "alarm register");
      wr(INT_STAT_OFS, 32'h4);
      ticks(3);
      chk({31'h0, irq}, 32'h0, "irq cleared");
      @(posedge pclk);
      alarm_in <= 1'b0;
      ticks(4);
      chk({28'h0, al, flt}, 32'h0, "alarm removed");
      @(posedge pclk);
      enc <= 3'h4;
      ticks(3);
      chk({29'h0, qa, qb, qc}, 32'h4, "encoder pass");
      wr(CTRL_OFS, 32'h4);
      ticks(3);
      chk({30'h0, qa, qb}, 32'h1, "encoder inverted");
      @(posedge pclk);
      enc <= 3'h5;
      ticks(3);
      chk({30'h0, qc, mark}, 32'h3, "index seen");
      @(posedge pclk);
      enc <= 3'h4;
      ticks(INDEX_HOLD_CYC - 10);
      chk({31'h0, mark}, 32'h1, "index mark held");
      ticks(20);
      chk({31'h0, mark}, 32'h0, "index mark ended");
      wr(CTRL_OFS, 32'h0);
      @(posedge pclk);
      rev_count <= 16'ha5c3;
      ask <= 1'b1;
      for (int i = 0; i < 2000 && frames === 8'h00; i++) @(posedge pclk);
      @(posedge pclk);
      ask <= 1'b0;
      chk({16'h0, word}, 32'ha5c3, "revolution frame");
      chk({31'h0, a_bad}, 32'h0, "frame on quad a and stop bit");
      chk({24'h0, frames}, 32'h1, "one frame after request dropped");
      ticks(600);
      chk({31'h0, ser}, 32'h1, "serial idle");
      wr(CTRL_OFS, 32'h8);
      @(posedge pclk);
      rev_count <= 16'h1234;
      enc <= 3'h1;
      for (int i = 0; i < 2000 && frames === 8'h01; i++) @(posedge pclk);
      chk({16'h0, word}, 32'h1234, "frame on index edge");
      @(posedge pclk);
      ce <= 1'b0;
      enc <= 3'h4;
      ticks(5);
      chk({30'h0, qa, qc}, 32'h1, "outputs frozen by clock enable");
      @(posedge pclk);
      ce <= 1'b1;
      ticks(3);
      chk({30'h0, qa, qc}, 32'h2, "outputs follow after enable");
      stop_test();
   end
endmodule : servo_status_out_tb
`default_nettype wire

// ===== verilog/mag_compare.sv
// Registered magnitude comparator of a signed difference against a width or level
`timescale 1ns/10ps
`default_nettype none
module mag_compare #(
   parameter int W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic tick,
   input wire logic gate,
   input wire servo_status_pkg::cmp_mode_t mode,
   input wire logic [W-1:0] a,
   input wire logic [W-1:0] b,
   input wire logic [W-1:0] lim,
   output logic hit_r
);
   import servo_status_pkg::*;

   logic [W:0] diff;
   logic [W:0] mag;
   logic [W:0] lim_x;
   logic hit_nxt;

   // Sign-extended so the difference never wraps
   assign diff = {a[W-1], a} - {b[W-1], b};
   assign mag = diff[W] ? (~diff + 1'b1) : diff;
   assign lim_x = {1'b0, lim};

   always_comb begin
      case (mode)
         CMP_WITHIN: hit_nxt = mag <= lim_x;
         CMP_REACH: hit_nxt = mag >= lim_x;
         CMP_EXCEED: hit_nxt = mag > lim_x;
         default: hit_nxt = 1'b0;
      endcase
   end

   // Evaluated once per control cycle only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hit_r <= 1'b0;
      end else if (ce && tick) begin
         hit_r <= gate && hit_nxt;
      end
   end
endmodule : mag_compare
`default_nettype wire

// ===== verilog/servo_status_out.sv
// Status, alarm and encoder retransmission outputs of a servo drive, with APB registers
//
// The placing of the registers and the APB register port were decided locally.
`timescale 1ns/10ps
`default_nettype none
module servo_status_out #(
   parameter int POS_W = 24,
   parameter int SPD_W = 16,
   parameter int REV_W = 16
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [POS_W-1:0] pos_err,
   input wire logic [SPD_W-1:0] speed_cmd,
   input wire logic [SPD_W-1:0] speed_meas,
   input wire logic [SPD_W-1:0] torque_out,
   input wire logic warning_in,
   input wire logic alarm_in,
   input wire logic [2:0] alarm_code_in,
   input wire servo_status_pkg::enc_in_t enc,
   input wire logic [REV_W-1:0] rev_count,
   input wire logic abs_req,
   output logic positioning_done_flag,
   output logic approach_flag,
   output logic speed_match_flag,
   output logic rotation_detect_flag,
   output logic torque_limit_flag,
   output logic speed_limit_flag,
   output logic warning_flag,
   output logic brake_control_out,
   output logic alarm_code_bit0,
   output logic alarm_code_bit1,
   output logic alarm_code_bit2,
   output logic fault_output,
   output logic quad_out_a,
   output logic quad_out_b,
   output logic index_out_c,
   output logic revolution_serial_out,
   output logic index_mark_out,
   output logic irq
);
   import servo_status_pkg::*;

   typedef enum {SER_IDLE, SER_START, SER_DATA, SER_STOP} ser_state_t;

   logic [4:0] ctrl_r;
   logic [23:0] compl_w_r, appr_w_r, coinc_w_r, rot_lvl_r, trq_lim_r, spd_lim_r;
   logic [IRQ_W-1:0] int_stat_r, int_mask_r, int_set;
   logic [7:0] ctrl_cnt_r;
   logic tick_r;
   logic pos_mode;
   logic inv;
   logic wr_en, rd_setup;
   logic [31:0] rd_nxt;
   logic rd_err;
   flags_t flags;
   logic done_prev_r, warn_prev_r, fault_prev_r, c_prev_r;
   logic [7:0] idx_cnt_r;
   ser_state_t ser_state_r;
   logic [7:0] bit_tmr_r;
   logic [7:0] bit_idx_r;
   logic [REV_W-1:0] sh_r;
   logic ser_line_r, ser_clk_r;
   logic abs_xfer, ser_go, bit_end;

   assign pos_mode = ctrl_r[CTRL_MODE_LSB +: 2] == MODE_POS;
   assign inv = ctrl_r[CTRL_INV_BIT];
   assign abs_xfer = abs_req && pos_mode;

   // Control cycle tick
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_cnt_r <= 8'h00;
         tick_r <= 1'b0;
      end else if (ce) begin
         tick_r <= ctrl_cnt_r == 8'(CTRL_CYC - 1);
         ctrl_cnt_r <= (ctrl_cnt_r == 8'(CTRL_CYC - 1)) ? 8'h00 : ctrl_cnt_r + 8'h01;
      end
   end

   // Comparator flags
   mag_compare #(.W(POS_W)) u_done (.pclk(pclk), .presetn(presetn), .ce(ce), .tick(tick_r),
      .gate(pos_mode), .mode(CMP_WITHIN), .a(pos_err), .b('0),
      .lim(POS_W'(compl_w_r)), .hit_r(positioning_done_flag));
   mag_compare #(.W(POS_W)) u_appr (.pclk(pclk), .presetn(presetn), .ce(ce), .tick(tick_r),
      .gate(pos_mode), .mode(CMP_WITHIN), .a(pos_err), .b('0),
      .lim(POS_W'(appr_w_r)), .hit_r(approach_flag));
   mag_compare #(.W(SPD_W)) u_coin (.pclk(pclk), .presetn(presetn), .ce(ce), .tick(tick_r),
      .gate(1'b1), .mode(CMP_WITHIN), .a(speed_cmd), .b(speed_meas),
      .lim(SPD_W'(coinc_w_r)), .hit_r(speed_match_flag));
   mag_compare #(.W(SPD_W)) u_rot (.pclk(pclk), .presetn(presetn), .ce(ce), .tick(tick_r),
      .gate(1'b1), .mode(CMP_EXCEED), .a(speed_meas), .b('0),
      .lim(SPD_W'(rot_lvl_r)), .hit_r(rotation_detect_flag));
   mag_compare #(.W(SPD_W)) u_trq (.pclk(pclk), .presetn(presetn), .ce(ce), .tick(tick_r),
      .gate(1'b1), .mode(CMP_REACH), .a(torque_out), .b('0),
      .lim(SPD_W'(trq_lim_r)), .hit_r(torque_limit_flag));
   mag_compare #(.W(SPD_W)) u_spd (.pclk(pclk), .presetn(presetn), .ce(ce), .tick(tick_r),
      .gate(1'b1), .mode(CMP_REACH), .a(speed_meas), .b('0),
      .lim(SPD_W'(spd_lim_r)), .hit_r(speed_limit_flag));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         warning_flag <= 1'b0;
      end else if (ce && tick_r) begin
         warning_flag <= warning_in;
      end
   end

   assign flags = '{warning: warning_flag, speed_limit: speed_limit_flag,
                    torque_limit: torque_limit_flag, rotation: rotation_detect_flag,
                    speed_match: speed_match_flag, approach: approach_flag,
                    done: positioning_done_flag};

   // Alarm, fault and brake; an alarm forces the brake to hold
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {alarm_code_bit2, alarm_code_bit1, alarm_code_bit0} <= 3'h0;
         fault_output <= 1'b0;
         brake_control_out <= 1'b0;
      end else if (ce) begin
         {alarm_code_bit2, alarm_code_bit1, alarm_code_bit0} <=
            alarm_in ? alarm_code_in : 3'h0;
         fault_output <= alarm_in;
         brake_control_out <= ctrl_r[CTRL_BRAKE_BIT] && !alarm_in;
      end
   end

   // Index mark stretched so a slow receiver sees it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         idx_cnt_r <= 8'h00;
         index_mark_out <= 1'b0;
      end else if (ce) begin
         if (enc.c) begin
            idx_cnt_r <= 8'(INDEX_HOLD_CYC - 1);
            index_mark_out <= 1'b1;
         end else if (idx_cnt_r != 8'h00) begin
            idx_cnt_r <= idx_cnt_r - 8'h01;
         end else begin
            index_mark_out <= 1'b0;
         end
      end
   end

   // Serial frame: low start bit, count LSB first, high stop bit; B carries bit clock only for an abs_req frame in position mode
   assign bit_end = bit_tmr_r == 8'(SER_BIT_CYC - 1);
   assign ser_go = abs_xfer || (ctrl_r[CTRL_ABS_BIT] && enc.c && !c_prev_r);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ser_state_r <= SER_IDLE;
         bit_tmr_r <= 8'h00;
         bit_idx_r <= 8'h00;
         sh_r <= '0;
         ser_line_r <= 1'b1;
         ser_clk_r <= 1'b0;
      end else if (ce) begin
         bit_tmr_r <= (ser_state_r == SER_IDLE || bit_end) ? 8'h00 : bit_tmr_r + 8'h01;
         ser_clk_r <= ser_state_r != SER_IDLE && bit_tmr_r < 8'(SER_HALF_CYC);
         case (ser_state_r)
            SER_IDLE: begin
               ser_line_r <= 1'b1;
               if (ser_go) begin
                  sh_r <= rev_count;
                  ser_line_r <= 1'b0;
                  ser_state_r <= SER_START;
               end
            end
            SER_START: begin
               if (bit_end) begin
                  ser_line_r <= sh_r[0];
                  bit_idx_r <= 8'h00;
                  ser_state_r <= SER_DATA;
               end
            end
            SER_DATA: begin
               if (bit_end) begin
                  if (bit_idx_r == 8'(REV_W - 1)) begin
                     ser_line_r <= 1'b1;
                     ser_state_r <= SER_STOP;
                  end else begin
                     ser_line_r <= sh_r[1];
                     sh_r <= sh_r >> 1;
                     bit_idx_r <= bit_idx_r + 8'h01;
                  end
               end
            end
            SER_STOP: begin
               if (bit_end) begin
                  ser_state_r <= SER_IDLE;
               end
            end
            default: ser_state_r <= SER_IDLE;
         endcase
      end
   end

   // Encoder retransmission and absolute data path
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         quad_out_a <= 1'b0;
         quad_out_b <= 1'b0;
         index_out_c <= 1'b0;
         revolution_serial_out <= 1'b1;
         c_prev_r <= 1'b0;
      end else if (ce) begin
         c_prev_r <= enc.c;
         index_out_c <= enc.c;
         revolution_serial_out <= ser_line_r;
         if (abs_xfer) begin
            quad_out_a <= ser_line_r;
            quad_out_b <= ser_clk_r;
         end else begin
            quad_out_a <= enc.a ^ inv;
            quad_out_b <= enc.b ^ inv;
         end
      end
   end

   // Interrupt events on rising edges
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {done_prev_r, warn_prev_r, fault_prev_r} <= 3'h0;
      end else if (ce) begin
         {done_prev_r, warn_prev_r, fault_prev_r} <=
            {positioning_done_flag, warning_flag, fault_output};
      end
   end

   always_comb begin
      int_set = '0;
      int_set[IRQ_DONE_BIT] = positioning_done_flag && !done_prev_r;
      int_set[IRQ_WARN_BIT] = warning_flag && !warn_prev_r;
      int_set[IRQ_FAULT_BIT] = fault_output && !fault_prev_r;
      int_set[IRQ_INDEX_BIT] = enc.c && !c_prev_r;
   end

   // APB slave: zero wait states, read data captured in the setup phase, write data taken in the access phase
   assign wr_en = psel && penable && pwrite;
   assign rd_setup = psel && !penable;

   always_comb begin
      rd_nxt = 32'h0;
      rd_err = 1'b0;
      case (paddr)
         CTRL_OFS: rd_nxt = 32'(ctrl_r);
         COMPL_W_OFS: rd_nxt = 32'(compl_w_r);
         APPR_W_OFS: rd_nxt = 32'(appr_w_r);
         COINC_W_OFS: rd_nxt = 32'(coinc_w_r);
         ROT_LVL_OFS: rd_nxt = 32'(rot_lvl_r);
         TRQ_LIM_OFS: rd_nxt = 32'(trq_lim_r);
         SPD_LIM_OFS: rd_nxt = 32'(spd_lim_r);
         STATUS_OFS: rd_nxt = 32'(flags);
         INT_STAT_OFS: rd_nxt = 32'(int_stat_r);
         INT_MASK_OFS: rd_nxt = 32'(int_mask_r);
         ALARM_OFS: rd_nxt = 32'({fault_output, alarm_code_bit2, alarm_code_bit1,
                                  alarm_code_bit0});
         default: rd_err = 1'b1;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0;
         pslverr <= 1'b0;
         pready <= 1'b0;
      end else if (ce) begin
         pready <= 1'b1;
         if (rd_setup) begin
            prdata <= pwrite ? 32'h0 : rd_nxt;
            pslverr <= rd_err;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r <= CTRL_RST;
         compl_w_r <= COMPL_W_RST;
         appr_w_r <= APPR_W_RST;
         coinc_w_r <= COINC_W_RST;
         rot_lvl_r <= ROT_LVL_RST;
         trq_lim_r <= TRQ_LIM_RST;
         spd_lim_r <= SPD_LIM_RST;
         int_mask_r <= INT_MASK_RST;
      end else if (ce && wr_en) begin
         case (paddr)
            CTRL_OFS: ctrl_r <= pwdata[4:0];
            COMPL_W_OFS: compl_w_r <= pwdata[23:0];
            APPR_W_OFS: appr_w_r <= pwdata[23:0];
            COINC_W_OFS: coinc_w_r <= pwdata[23:0];
            ROT_LVL_OFS: rot_lvl_r <= pwdata[23:0];
            TRQ_LIM_OFS: trq_lim_r <= pwdata[23:0];
            SPD_LIM_OFS: spd_lim_r <= pwdata[23:0];
            INT_MASK_OFS: int_mask_r <= pwdata[IRQ_W-1:0];
            default: ;
         endcase
      end
   end

   // Set wins over a simultaneous write-one-to-clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_stat_r <= '0;
         irq <= 1'b0;
      end else if (ce) begin
         int_stat_r <= (int_stat_r & ~((wr_en && paddr == INT_STAT_OFS) ?
            pwdata[IRQ_W-1:0] : '0)) | int_set;
         irq <= |(int_stat_r & int_mask_r);
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   AST_DONE_IN: assert property (ce && tick_r && pos_mode && !pos_err[POS_W-1] &&
      pos_err <= POS_W'(compl_w_r) |=> positioning_done_flag)
      else $error("done flag not set inside completion width");
   AST_APPR_MODE: assert property (ce && tick_r && !pos_mode |=> !approach_flag)
      else $error("approach flag set outside position mode");
   AST_MATCH: assert property (ce && tick_r && speed_cmd == speed_meas |=>
      speed_match_flag) else $error("speed match missed at equal speeds");
   AST_ROT_ZERO: assert property (ce && tick_r && speed_meas == '0 |=>
      !rotation_detect_flag) else $error("rotation flagged at zero speed");
   AST_HOLD: assert property (!(ce && tick_r) |=> $stable(flags))
      else $error("flag changed between control cycles");
   AST_ALARM: assert property (ce && alarm_in |=> fault_output && !brake_control_out &&
      {alarm_code_bit2, alarm_code_bit1, alarm_code_bit0} == $past(alarm_code_in))
      else $error("alarm outputs wrong after alarm");
   AST_INV: assert property (ce && !abs_xfer |=> quad_out_a == ($past(enc.a) ^
      $past(inv))) else $error("A output polarity wrong");
   AST_ABS_START: assert property (ce && abs_xfer && ser_state_r == SER_IDLE ##1 ce
      |=> !revolution_serial_out) else $error("absolute frame did not start");
   AST_INDEX: assert property (ce && enc.c |=> index_mark_out ##1 index_mark_out)
      else $error("index mark not held");
endmodule : servo_status_out
`default_nettype wire

// ===== verilog/servo_status_pkg.sv
// Package of register map, field layout, timing and shared types for the status output block
package servo_status_pkg;
   // Clock and timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int CTRL_PERIOD_NS = 1000;
   localparam int CTRL_CYC = (CTRL_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SER_BIT_NS = 500;
   localparam int SER_BIT_CYC = (SER_BIT_NS / CLK_PERIOD_NS) < 2 ? 2 : SER_BIT_NS / CLK_PERIOD_NS;
   localparam int SER_HALF_CYC = SER_BIT_CYC / 2;
   localparam int INDEX_HOLD_NS = 2000;
   localparam int INDEX_HOLD_CYC = (INDEX_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

   // Register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] COMPL_W_OFS = 8'h04;
   localparam logic [7:0] APPR_W_OFS = 8'h08;
   localparam logic [7:0] COINC_W_OFS = 8'h0c;
   localparam logic [7:0] ROT_LVL_OFS = 8'h10;
   localparam logic [7:0] TRQ_LIM_OFS = 8'h14;
   localparam logic [7:0] SPD_LIM_OFS = 8'h18;
   localparam logic [7:0] STATUS_OFS = 8'h1c;
   localparam logic [7:0] INT_STAT_OFS = 8'h20;
   localparam logic [7:0] INT_MASK_OFS = 8'h24;
   localparam logic [7:0] ALARM_OFS = 8'h28;

   // CTRL fields
   localparam int CTRL_MODE_LSB = 0;
   localparam int CTRL_INV_BIT = 2;
   localparam int CTRL_ABS_BIT = 3;
   localparam int CTRL_BRAKE_BIT = 4;
   localparam logic [4:0] CTRL_RST = 5'h00;

   // Interrupt status bits
   localparam int IRQ_DONE_BIT = 0;
   localparam int IRQ_WARN_BIT = 1;
   localparam int IRQ_FAULT_BIT = 2;
   localparam int IRQ_INDEX_BIT = 3;
   localparam int IRQ_W = 4;
   localparam logic [3:0] INT_MASK_RST = 4'h0;

   // Reset values of width and level parameters
   localparam logic [23:0] COMPL_W_RST = 24'h00000a;
   localparam logic [23:0] APPR_W_RST = 24'h000064;
   localparam logic [23:0] COINC_W_RST = 24'h00000a;
   localparam logic [23:0] ROT_LVL_RST = 24'h000014;
   localparam logic [23:0] TRQ_LIM_RST = 24'h007fff;
   localparam logic [23:0] SPD_LIM_RST = 24'h007fff;

   typedef enum logic [1:0] {MODE_POS, MODE_SPEED, MODE_TORQUE, MODE_TERM} ctrl_mode_t;
   typedef enum logic [1:0] {CMP_WITHIN, CMP_REACH, CMP_EXCEED} cmp_mode_t;

   typedef struct packed {
      logic a;
      logic b;
      logic c;
   } enc_in_t;

   typedef struct packed {
      logic warning;
      logic speed_limit;
      logic torque_limit;
      logic rotation;
      logic speed_match;
      logic approach;
      logic done;
   } flags_t;
endpackage : servo_status_pkg
